// *** rtl/mie_core.sv ***
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "mie_regs.svh"
module mie_core (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// program memory
	output logic [12:0]      progAddr,
	input  wire logic [14:0] progData,
	// pins and events
	input  wire logic [7:0]  portIn,
	output logic [7:0]       portOut,
	input  wire logic        wakeUp,
	input  wire logic        wdtTimeout,
	output logic             wdtClear,
	output logic             sleeping,
	output logic             irqEnable,
	// axi4-lite write
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	import mie_pkg::*;

	mie_state_e  state;
	mie_state_e  next_state;
	logic [12:0] pc;
	logic [12:0] next_pc;
	logic [14:0] instr;
	logic [7:0]  acc;
	logic [7:0]  statusReg;
	logic [7:0]  regFile [0:63];
	logic [7:0]  rdVal;
	logic [7:0]  wrData;
	logic [7:0]  bitMask;
	logic [5:0]  rAddr;
	logic        cyc;
	logic        tick;
	logic        run;
	logic        wakeSw;
	logic        longCall;
	logic        accWe;
	logic        regWe;
	logic        zWe;
	logic        cWe;
	logic        hcWe;
	logic        skipBit;
	logic        skipZero;
	logic        skip;
	logic        pcWrite;
	logic        pushEn;
	logic        popEn;
	logic        slpGo;
	logic        wdtGo;
	logic        irqOn;
	logic        irqOff;
	logic        longGo;
	mie_grp_e    grp;
	mie_regop_e  regOp;
	mie_misc_e   miscOp;
	mie_litop_e  litOp;
	mie_bitop_e  bitOp;

	mie_dp_if dp ();

	mie_alu uAlu (
		.ifc (dp.alu)
	);

	mie_stack uStack (
		.clk (clk),
		.rst (rst),
		.ifc (dp.stk)
	);

	////////////////////////////////////////////////////////////////////////////////
	// instruction cycle: fetch on the first clock, execute on the second

	always_ff @(posedge clk) begin
		if (rst) begin
			cyc <= 1'b0;
		end else begin
			cyc <= (cyc == 1'(`MIE_CLK_PER_CYCLE - 1)) ? 1'b0 : 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			instr <= 15'h0000;
		end else if (!cyc) begin
			instr <= progData;
		end
	end

	assign tick     = cyc && run;
	assign progAddr = pc;
	assign grp      = mie_grp_e'(instr[`MIE_F_GRP]);
	assign regOp    = mie_regop_e'(instr[`MIE_F_OP]);
	assign miscOp   = mie_misc_e'(instr[`MIE_F_MISC]);
	assign litOp    = mie_litop_e'(instr[`MIE_F_OP]);
	assign bitOp    = mie_bitop_e'(instr[`MIE_F_BOP]);
	assign rAddr    = instr[`MIE_F_REG];
	assign bitMask  = 8'h01 << instr[`MIE_F_BIT];

	// special registers share the operand path with general ones
	always_comb begin
		case (rAddr)
			`MIE_RF_PCL:    rdVal = pc[7:0];
			`MIE_RF_STATUS: rdVal = statusReg;
			`MIE_RF_PORT:   rdVal = portIn;
			default:        rdVal = regFile[rAddr];
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// decode

	always_comb begin
		dp.op = MIE_ALU_PASS;
		dp.a = acc;
		dp.b = rdVal;
		dp.cin = statusReg[`MIE_SF_C];
		accWe = 1'b0;
		regWe = 1'b0;
		zWe = 1'b0;
		cWe = 1'b0;
		hcWe = 1'b0;
		skipBit = 1'b0;
		skipZero = 1'b0;
		pushEn = 1'b0;
		popEn = 1'b0;
		slpGo = 1'b0;
		wdtGo = 1'b0;
		irqOn = 1'b0;
		irqOff = 1'b0;
		longGo = 1'b0;
		next_pc = 13'(pc + 13'h0001);
		next_state = MIE_ST_EXEC;
		case (state)
			MIE_ST_EXEC: begin
				case (grp)
					MIE_GRP_REG: begin
						if (regOp == MIE_OP_MISC) begin
							case (miscOp)
								MIE_MISC_SLEEP: begin
									slpGo = 1'b1;
									next_state = MIE_ST_SLEEP;
								end
								MIE_MISC_WDT: wdtGo = 1'b1;
								MIE_MISC_IRQ_ON: irqOn = 1'b1;
								MIE_MISC_IRQ_OFF: irqOff = 1'b1;
								MIE_MISC_RET, MIE_MISC_RET_IRQ: begin
									next_pc = dp.top;
									popEn = 1'b1;
									irqOn = (miscOp == MIE_MISC_RET_IRQ);
									next_state = MIE_ST_WAIT;
								end
								MIE_MISC_CLRA: begin
									dp.op = MIE_ALU_ZERO;
									accWe = 1'b1;
									zWe = 1'b1;
								end
								default: begin
									accWe = 1'b0;
								end
							endcase
						end else begin
							accWe = !instr[`MIE_F_DST];
							regWe = instr[`MIE_F_DST];
							case (regOp)
								MIE_OP_SUB_A, MIE_OP_SUB_R, MIE_OP_ADD_A, MIE_OP_ADD_R: begin
									zWe = 1'b1;
									cWe = 1'b1;
									hcWe = 1'b1;
								end
								MIE_OP_ROR_A, MIE_OP_ROR_R, MIE_OP_ROL_A, MIE_OP_ROL_R: cWe = 1'b1;
								MIE_OP_DSKIP_A, MIE_OP_DSKIP_R, MIE_OP_ISKIP_A, MIE_OP_ISKIP_R: skipZero = 1'b1;
								MIE_OP_STORE, MIE_OP_SWAP_A, MIE_OP_SWAP_R: zWe = 1'b0;
								default: zWe = 1'b1;
							endcase
							case (regOp)
								MIE_OP_STORE: dp.b = acc;
								MIE_OP_CLR: dp.op = MIE_ALU_ZERO;
								MIE_OP_SUB_A, MIE_OP_SUB_R: dp.op = MIE_ALU_SUB;
								MIE_OP_DEC_A, MIE_OP_DEC_R, MIE_OP_DSKIP_A, MIE_OP_DSKIP_R: dp.op = MIE_ALU_DEC;
								MIE_OP_OR_A, MIE_OP_OR_R: dp.op = MIE_ALU_OR;
								MIE_OP_AND_A, MIE_OP_AND_R: dp.op = MIE_ALU_AND;
								MIE_OP_XOR_A, MIE_OP_XOR_R: dp.op = MIE_ALU_XOR;
								MIE_OP_ADD_A, MIE_OP_ADD_R: dp.op = MIE_ALU_ADD;
								MIE_OP_LOAD_A, MIE_OP_MOVE_R: dp.op = MIE_ALU_PASS;
								MIE_OP_COM_A, MIE_OP_COM_R: dp.op = MIE_ALU_COM;
								MIE_OP_INC_A, MIE_OP_INC_R, MIE_OP_ISKIP_A, MIE_OP_ISKIP_R: dp.op = MIE_ALU_INC;
								MIE_OP_ROR_A, MIE_OP_ROR_R: dp.op = MIE_ALU_ROR;
								MIE_OP_ROL_A, MIE_OP_ROL_R: dp.op = MIE_ALU_ROL;
								MIE_OP_SWAP_A, MIE_OP_SWAP_R: dp.op = MIE_ALU_SWAP;
								default: begin
									accWe = 1'b0;
									regWe = 1'b0;
									zWe = 1'b0;
								end
							endcase
						end
					end
					MIE_GRP_BIT: begin
						case (bitOp)
							MIE_BIT_CLR: begin
								dp.b = rdVal & ~bitMask;
								regWe = 1'b1;
							end
							MIE_BIT_SET: begin
								dp.b = rdVal | bitMask;
								regWe = 1'b1;
							end
							MIE_BIT_SKIP_LOW: skipBit = ~|(rdVal & bitMask);
							MIE_BIT_SKIP_HIGH: skipBit = |(rdVal & bitMask);
							default: skipBit = 1'b0;
						endcase
					end
					MIE_GRP_LIT: begin
						dp.b = instr[`MIE_F_K8];
						case (litOp)
							MIE_LIT_MOV: accWe = 1'b1;
							MIE_LIT_OR, MIE_LIT_AND, MIE_LIT_XOR: begin
								dp.op = (litOp == MIE_LIT_OR) ? MIE_ALU_OR :
									(litOp == MIE_LIT_AND) ? MIE_ALU_AND : MIE_ALU_XOR;
								accWe = 1'b1;
								zWe = 1'b1;
							end
							MIE_LIT_SUB, MIE_LIT_ADD: begin
								dp.op = (litOp == MIE_LIT_SUB) ? MIE_ALU_SUB : MIE_ALU_ADD;
								accWe = 1'b1;
								zWe = 1'b1;
								cWe = 1'b1;
								hcWe = 1'b1;
							end
							MIE_LIT_RET: begin
								accWe = 1'b1;
								popEn = 1'b1;
								next_pc = dp.top;
								next_state = MIE_ST_WAIT;
							end
							MIE_LIT_LONG_CALL, MIE_LIT_LJUMP: begin
								longGo = 1'b1;
								next_state = MIE_ST_LONG;
							end
							default: accWe = 1'b0;
						endcase
					end
					default: begin
						next_pc = {pc[12], instr[`MIE_F_K12]};
						pushEn = instr[`MIE_F_CALL];
						next_state = MIE_ST_WAIT;
					end
				endcase
			end
			MIE_ST_DISCARD: next_state = MIE_ST_EXEC;
			MIE_ST_WAIT: next_pc = pc;
			MIE_ST_LONG: begin
				next_pc = instr[`MIE_F_TGT];
				pushEn = longCall;
			end
			MIE_ST_SLEEP: begin
				next_pc = pc;
				next_state = (wakeUp || wakeSw) ? MIE_ST_EXEC : MIE_ST_SLEEP;
			end
			default: next_state = MIE_ST_EXEC;
		endcase
	end

	assign wrData     = dp.res;
	assign pcWrite    = regWe && (rAddr == `MIE_RF_PCL);
	assign skip       = skipBit || (skipZero && dp.zOut);
	assign dp.push    = tick && pushEn;
	assign dp.pop     = tick && popEn;
	assign dp.pushVal = 13'(pc + 13'h0001);
	assign sleeping   = (state == MIE_ST_SLEEP);

	////////////////////////////////////////////////////////////////////////////////
	// execute

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= MIE_ST_EXEC;
		end else if (tick) begin
			if (pcWrite) begin
				state <= MIE_ST_WAIT;
			end else if (skip) begin
				state <= MIE_ST_DISCARD;
			end else begin
				state <= next_state;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pc <= `MIE_PC_RST;
		end else if (tick) begin
			pc <= pcWrite ? {pc[12:8], wrData} : next_pc;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			acc <= 8'h00;
		end else if (tick && accWe) begin
			acc <= wrData;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < 64; i++) begin
				regFile[i] <= 8'h00;
			end
		end else if (tick && regWe) begin
			regFile[rAddr] <= wrData;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			portOut <= `MIE_PORT_RST;
		end else if (tick && regWe && rAddr == `MIE_RF_PORT) begin
			portOut <= wrData;
		end
	end

	// an instruction's own flag update overrides a direct write of the status byte
	always_ff @(posedge clk) begin
		if (rst) begin
			statusReg <= `MIE_STATUS_RST;
		end else begin
			if (tick && regWe && rAddr == `MIE_RF_STATUS) begin
				statusReg[`MIE_SF_Z:`MIE_SF_C] <= wrData[`MIE_SF_Z:`MIE_SF_C];
			end
			if (tick && zWe) begin
				statusReg[`MIE_SF_Z] <= dp.zOut;
			end
			if (tick && cWe) begin
				statusReg[`MIE_SF_C] <= dp.cout;
			end
			if (tick && hcWe) begin
				statusReg[`MIE_SF_HC] <= dp.hcOut;
			end
			if (wdtTimeout) begin
				statusReg[`MIE_SF_T] <= 1'b0;
			end
			if (tick && (wdtGo || slpGo)) begin
				statusReg[`MIE_SF_T] <= 1'b1;
				statusReg[`MIE_SF_P] <= wdtGo;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wdtClear <= 1'b0;
			irqEnable <= 1'b0;
			longCall <= 1'b0;
		end else begin
			wdtClear <= tick && (wdtGo || slpGo);
			if (tick && irqOn) begin
				irqEnable <= 1'b1;
			end else if (tick && irqOff) begin
				irqEnable <= 1'b0;
			end
			if (tick && longGo) begin
				longCall <= (litOp == MIE_LIT_LONG_CALL);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite slave

	logic        awHeld;
	logic        wHeld;
	logic [3:0]  awAddrQ;
	logic [31:0] wDataQ;
	logic [3:0]  wStrbQ;
	logic [31:0] rdWord;
	logic        rdErr;
	logic        wrOk;

	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wrOk          = (awAddrQ[1:0] == 2'b00);

	always_ff @(posedge clk) begin
		if (rst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddrQ <= 4'h0;
			wDataQ <= 32'h00000000;
			wStrbQ <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `MIE_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddrQ <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wDataQ <= s_axi_wdata;
				wStrbQ <= s_axi_wstrb;
			end
			if (awHeld && wHeld) begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrOk ? `MIE_RESP_OKAY : `MIE_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			run <= `MIE_RUN_RST;
			wakeSw <= 1'b0;
		end else if (awHeld && wHeld && awAddrQ == `MIE_ADDR_CTRL && wStrbQ[0]) begin
			run <= wDataQ[`MIE_CTRL_RUN];
			wakeSw <= wDataQ[`MIE_CTRL_WAKE];
		end
	end

	always_comb begin
		rdWord = 32'h00000000;
		rdErr = 1'b0;
		case (s_axi_araddr)
			`MIE_ADDR_CTRL: rdWord = {30'h0, wakeSw, run};
			`MIE_ADDR_STAT: rdWord = {16'h0, statusReg, irqEnable, 2'h0, 5'(state)};
			`MIE_ADDR_PC:   rdWord = {19'h0, pc};
			`MIE_ADDR_ACC:  rdWord = {24'h0, acc};
			default:        rdErr = 1'b1;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `MIE_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdWord;
			s_axi_rresp <= rdErr ? `MIE_RESP_SLVERR : `MIE_RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// *** rtl/mie_regs.svh ***
`ifndef MIE_REGS_SVH
`define MIE_REGS_SVH
// Notes on behaviour
// - instruction is one 15-bit word, opcode plus operands
// - instruction cycle is two clocks, one cycle
// - program counter destination costs two cycles
// - taken skip costs two cycles
// - any register bit set, clear, test-skip
// - port register reached like any register
// - literals are 8-bit data or 12-bit target
// - sleep/watchdog-clear clear counter, update T and P
// - returns pop pc; irq-return also sets irq enable, plain return leaves it
// - add/sub update Z, C, HC; sub is operand-acc
// - logic, inc, dec, clear, register loads touch Z only; literal load touches no flags
// - rotates go through carry, eight bits
// - nibble swap in place or to acc, no flags
// - inc/dec skip on zero result, no flags
// - short call pushes, loads page plus 12 bits
// - long call/jump take 13-bit target next word
// - return with literal loads acc and pops pc

// axi4-lite byte offsets and responses
`define MIE_ADDR_CTRL     4'h0
`define MIE_ADDR_STAT     4'h4
`define MIE_ADDR_PC       4'h8
`define MIE_ADDR_ACC      4'hc
`define MIE_RESP_OKAY     2'b00
`define MIE_RESP_SLVERR   2'b10
// control register fields and reset
`define MIE_CTRL_RUN      0
`define MIE_CTRL_WAKE     1
`define MIE_RUN_RST       1'b1
// core register file addresses
`define MIE_RF_PCL        6'h02
`define MIE_RF_STATUS     6'h03
`define MIE_RF_PORT       6'h05
// status byte fields and reset
`define MIE_SF_C          0
`define MIE_SF_HC         1
`define MIE_SF_Z          2
`define MIE_SF_P          3
`define MIE_SF_T          4
`define MIE_STATUS_RST    8'h18
`define MIE_PC_RST        13'h0000
`define MIE_PORT_RST      8'h00
// instruction word fields
`define MIE_F_GRP         14:13
`define MIE_F_OP          12:8
`define MIE_F_DST         8
`define MIE_F_BOP         12:11
`define MIE_F_BIT         10:8
`define MIE_F_REG         5:0
`define MIE_F_MISC        3:0
`define MIE_F_K8          7:0
`define MIE_F_K12         11:0
`define MIE_F_CALL        12
`define MIE_F_TGT         12:0
// timing
`define MIE_CLK_PER_CYCLE 2
`define MIE_STACK_DEPTH   8
`endif

// *** rtl/mie_pkg.sv ***
package mie_pkg;
	typedef enum logic [4:0] {
		MIE_ST_EXEC    = 5'b00001,
		MIE_ST_DISCARD = 5'b00010,
		MIE_ST_WAIT    = 5'b00100,
		MIE_ST_LONG    = 5'b01000,
		MIE_ST_SLEEP   = 5'b10000
	} mie_state_e;
	typedef enum logic [1:0] {
		MIE_GRP_REG = 2'h0,
		MIE_GRP_BIT = 2'h1,
		MIE_GRP_LIT = 2'h2,
		MIE_GRP_JMP = 2'h3
	} mie_grp_e;
	// even codes other than MIE_OP_MISC write the accumulator, odd codes the register
	typedef enum logic [4:0] {
		MIE_OP_MISC = 5'h00, MIE_OP_STORE = 5'h01, MIE_OP_CLR = 5'h03,
		MIE_OP_SUB_A = 5'h04, MIE_OP_SUB_R = 5'h05, MIE_OP_DEC_A = 5'h06, MIE_OP_DEC_R = 5'h07,
		MIE_OP_OR_A = 5'h08, MIE_OP_OR_R = 5'h09, MIE_OP_AND_A = 5'h0a, MIE_OP_AND_R = 5'h0b,
		MIE_OP_XOR_A = 5'h0c, MIE_OP_XOR_R = 5'h0d, MIE_OP_ADD_A = 5'h0e, MIE_OP_ADD_R = 5'h0f,
		MIE_OP_LOAD_A = 5'h10, MIE_OP_MOVE_R = 5'h11, MIE_OP_COM_A = 5'h12, MIE_OP_COM_R = 5'h13,
		MIE_OP_INC_A = 5'h14, MIE_OP_INC_R = 5'h15, MIE_OP_DSKIP_A = 5'h16, MIE_OP_DSKIP_R = 5'h17,
		MIE_OP_ROR_A = 5'h18, MIE_OP_ROR_R = 5'h19, MIE_OP_ROL_A = 5'h1a, MIE_OP_ROL_R = 5'h1b,
		MIE_OP_SWAP_A = 5'h1c, MIE_OP_SWAP_R = 5'h1d, MIE_OP_ISKIP_A = 5'h1e, MIE_OP_ISKIP_R = 5'h1f
	} mie_regop_e;
	typedef enum logic [3:0] {
		MIE_MISC_NOP = 4'h0, MIE_MISC_SLEEP = 4'h1, MIE_MISC_WDT = 4'h2, MIE_MISC_IRQ_ON = 4'h3,
		MIE_MISC_IRQ_OFF = 4'h4, MIE_MISC_RET = 4'h5, MIE_MISC_RET_IRQ = 4'h6, MIE_MISC_CLRA = 4'h7
	} mie_misc_e;
	typedef enum logic [4:0] {
		MIE_LIT_MOV = 5'h00, MIE_LIT_OR = 5'h01, MIE_LIT_AND = 5'h02, MIE_LIT_XOR = 5'h03,
		MIE_LIT_RET = 5'h04, MIE_LIT_SUB = 5'h05, MIE_LIT_ADD = 5'h06,
		MIE_LIT_LONG_CALL = 5'h07, MIE_LIT_LJUMP = 5'h08
	} mie_litop_e;
	typedef enum logic [1:0] {
		MIE_BIT_CLR = 2'h0, MIE_BIT_SET = 2'h1, MIE_BIT_SKIP_LOW = 2'h2, MIE_BIT_SKIP_HIGH = 2'h3
	} mie_bitop_e;
	typedef enum logic [3:0] {
		MIE_ALU_PASS = 4'h0, MIE_ALU_ZERO = 4'h1, MIE_ALU_ADD = 4'h2, MIE_ALU_SUB = 4'h3,
		MIE_ALU_AND = 4'h4, MIE_ALU_OR = 4'h5, MIE_ALU_XOR = 4'h6, MIE_ALU_COM = 4'h7,
		MIE_ALU_INC = 4'h8, MIE_ALU_DEC = 4'h9, MIE_ALU_ROR = 4'ha, MIE_ALU_ROL = 4'hb,
		MIE_ALU_SWAP = 4'hc
	} mie_alu_op_e;
endpackage

// *** rtl/mie_dp_if.sv ***
`timescale 1ns/1ps
interface mie_dp_if;
	import mie_pkg::*;
	mie_alu_op_e op;
	logic [7:0]  a;
	logic [7:0]  b;
	logic        cin;
	logic [7:0]  res;
	logic        cout;
	logic        hcOut;
	logic        zOut;
	logic        push;
	logic        pop;
	logic [12:0] pushVal;
	logic [12:0] top;
	modport core (output op, a, b, cin, push, pop, pushVal, input res, cout, hcOut, zOut, top);
	modport alu (input op, a, b, cin, output res, cout, hcOut, zOut);
	modport stk (input push, pop, pushVal, output top);
endinterface

// *** rtl/mie_alu.sv ***
`timescale 1ns/1ps
module mie_alu (
	// datapath
	mie_dp_if.alu ifc
);
	import mie_pkg::*;
	logic [8:0] sum;
	logic [4:0] nib;

	always_comb begin
		sum = 9'h000;
		nib = 5'h00;
		ifc.res = ifc.b;
		ifc.cout = ifc.cin;
		ifc.hcOut = 1'b0;
		case (ifc.op)
			MIE_ALU_ZERO: ifc.res = 8'h00;
			MIE_ALU_ADD: begin
				sum = {1'b0, ifc.a} + {1'b0, ifc.b};
				nib = {1'b0, ifc.a[3:0]} + {1'b0, ifc.b[3:0]};
				ifc.res = sum[7:0];
				ifc.cout = sum[8];
				ifc.hcOut = nib[4];
			end
			// operand minus acc; carry set means no borrow
			MIE_ALU_SUB: begin
				sum = {1'b0, ifc.b} + {1'b0, ~ifc.a} + 9'h001;
				nib = {1'b0, ifc.b[3:0]} + {1'b0, ~ifc.a[3:0]} + 5'h01;
				ifc.res = sum[7:0];
				ifc.cout = sum[8];
				ifc.hcOut = nib[4];
			end
			MIE_ALU_AND: ifc.res = ifc.a & ifc.b;
			MIE_ALU_OR: ifc.res = ifc.a | ifc.b;
			MIE_ALU_XOR: ifc.res = ifc.a ^ ifc.b;
			MIE_ALU_COM: ifc.res = ~ifc.b;
			MIE_ALU_INC: ifc.res = ifc.b + 8'h01;
			MIE_ALU_DEC: ifc.res = ifc.b - 8'h01;
			MIE_ALU_ROR: begin
				ifc.res = {ifc.cin, ifc.b[7:1]};
				ifc.cout = ifc.b[0];
			end
			MIE_ALU_ROL: begin
				ifc.res = {ifc.b[6:0], ifc.cin};
				ifc.cout = ifc.b[7];
			end
			MIE_ALU_SWAP: ifc.res = {ifc.b[3:0], ifc.b[7:4]};
			default: ifc.res = ifc.b;
		endcase
	end

	assign ifc.zOut = (ifc.res == 8'h00);
endmodule

// *** rtl/mie_stack.sv ***
`timescale 1ns/1ps
`include "mie_regs.svh"
module mie_stack (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// push and pop
	mie_dp_if.stk     ifc
);
	logic [12:0] mem [0:`MIE_STACK_DEPTH-1];
	logic [2:0]  ptr;

	// circular: overflow overwrites the oldest entry
	assign ifc.top = mem[3'(ptr - 3'h1)];

	always_ff @(posedge clk) begin
		if (rst) begin
			ptr <= 3'h0;
		end else if (ifc.push) begin
			ptr <= 3'(ptr + 3'h1);
		end else if (ifc.pop) begin
			ptr <= 3'(ptr - 3'h1);
		end
	end

	always_ff @(posedge clk) begin
		if (ifc.push) begin
			mem[ptr] <= ifc.pushVal;
		end
	end
endmodule

// *** verification/mie_prog_mem.sv ***
`timescale 1ns/1ps
module mie_prog_mem (
	// fetch
	input  wire logic [12:0] progAddr,
	output logic [14:0]      progData
);
	logic [14:0] rom [0:8191];
	// one whole word per address, answered without delay
	assign progData = rom[progAddr];
	initial begin
		for (int i = 0; i < 8192; i++) begin
			rom[i] = 15'h0000;
		end
	end
endmodule

// *** verification/mie_core_properties.sv ***
`timescale 1ns/1ps
module mie_core_chk (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// core
	input wire logic [12:0] progAddr,
	input wire logic        wakeUp,
	input wire logic        wdtClear,
	input wire logic        sleeping,
	// bus
	input wire logic [3:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_pc_hold;
		$changed(progAddr) |=> $stable(progAddr);
	endproperty
	a_pc_hold: assert property (p_pc_hold) else $error("pc moved on two clocks in a row");
	property p_sleep_hold;
		sleeping && !wakeUp |=> $stable(progAddr);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("pc moved while asleep");
	property p_wdt_pulse;
		wdtClear |=> !wdtClear;
	endproperty
	a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog clear longer than one clock");
	property p_sleep_wdt;
		$rose(sleeping) |-> wdtClear || $past(wdtClear);
	endproperty
	a_sleep_wdt: assert property (p_sleep_wdt) else $error("sleep without watchdog clear");
	property p_rd_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken while answer pending");
	property p_r_stand;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_stand: assert property (p_r_stand) else $error("read answer dropped");
	property p_b_stand;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_stand: assert property (p_b_stand) else $error("write answer dropped");
	property p_misalign;
		s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'b00 |=> s_axi_rresp == 2'b10;
	endproperty
	a_misalign: assert property (p_misalign) else $error("misaligned read not refused");
	c_sleep: cover property ($rose(sleeping));
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_wdt: cover property (wdtClear);
endmodule
bind mie_core mie_core_chk i_chk (.clk(clk), .rst(rst), .progAddr(progAddr), .wakeUp(wakeUp),
	.wdtClear(wdtClear), .sleeping(sleeping), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));

// *** verification/mcu_instruction_execute_tb.sv ***
`timescale 1ns/1ps
module mcu_instruction_execute_tb;
	import mie_pkg::*;
	typedef struct packed {
		logic [14:0] w0;
		logic [14:0] w1;
		logic [14:0] w2;
		logic [7:0]  acc;
		logic [2:0]  flg;
	} mie_row_s;
	logic        clk = 0;
	logic        rst = 1;
	logic [12:0] progAddr;
	logic [14:0] progData;
	logic [7:0]  portIn = 0;
	logic [7:0]  portOut;
	logic        wakeUp = 0;
	logic        wdtTimeout = 0;
	logic        wdtClear, sleeping, irqEnable;
	logic [3:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, d;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, r;
	int          badCount = 0, checkCount = 0, cycles = 0;
	mie_row_s    rows [15] = '{
		'{15'h400f, 15'h4601, 15'h0, 8'h10, 3'b010}, '{15'h40ff, 15'h4601, 15'h0, 8'h00, 3'b111},
		'{15'h4001, 15'h4501, 15'h0, 8'h00, 3'b111}, '{15'h4002, 15'h4501, 15'h0, 8'hff, 3'b000},
		'{15'h40f0, 15'h420f, 15'h0, 8'h00, 3'b100}, '{15'h4055, 15'h4355, 15'h0, 8'h00, 3'b100},
		'{15'h40f0, 15'h410f, 15'h0, 8'hff, 3'b000}, '{15'h4081, 15'h0110, 15'h1810, 8'h40, 3'b001},
		'{15'h4081, 15'h0110, 15'h1a10, 8'h02, 3'b001}, '{15'h403c, 15'h0110, 15'h1c10, 8'hc3, 3'b000},
		'{15'h40ff, 15'h0110, 15'h1410, 8'h00, 3'b100}, '{15'h4000, 15'h0110, 15'h1210, 8'hff, 3'b000},
		'{15'h40a5, 15'h0007, 15'h0, 8'h00, 3'b100}, '{15'h4001, 15'h0110, 15'h0610, 8'h00, 3'b100},
		'{15'h4003, 15'h0102, 15'h4077, 8'h03, 3'b000}};
	always #4 clk = ~clk;
	mie_prog_mem i_mem (.progAddr(progAddr), .progData(progData));
	mie_core i_dut (.clk(clk), .rst(rst), .progAddr(progAddr), .progData(progData), .portIn(portIn),
		.portOut(portOut), .wakeUp(wakeUp), .wdtTimeout(wdtTimeout), .wdtClear(wdtClear), .sleeping(sleeping),
		.irqEnable(irqEnable), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checkCount++;
		if (s !== e) begin
			badCount++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic testDone();
		$display("checks %0d mismatches %0d", checkCount, badCount);
		if (badCount == 0 && checkCount > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		logic aw;
		logic w;
		aw = 0;
		w = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk);
			if (!aw && awready === 1'b1) begin
				aw = 1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1) begin
				w = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	// load a program during reset, then let it run to its closing loop
	task automatic boot(input logic [14:0] p [$]);
		@(posedge clk);
		rst <= 1'b1;
		for (int i = 0; i < 16; i++) i_mem.rom[i] = (i < p.size()) ? p[i] : 15'h0000;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (60) @(posedge clk);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			badCount++;
			testDone();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		foreach (rows[i]) begin
			boot('{rows[i].w0, rows[i].w1, rows[i].w2, 15'h6003});
			rd(4'hc);
			chk("acc", d, {24'h0, rows[i].acc});
			rd(4'h4);
			chk("flags", 32'(d[10:8]), 32'(rows[i].flg));
			rd(4'h8);
			chk("pc", d, 32'h3);
		end
		$display("table test done");
		boot('{15'h4001, 15'h0110, 15'h1610, 15'h1510, 15'h2b10, 15'h3b10, 15'h1510, 15'h1010, 15'h6008});
		rd(4'hc);
		chk("acc", d, 32'h09);
		rd(4'h8);
		chk("pc", d, 32'h8);
		$display("skip test done");
		boot('{15'h4700, 15'h0005, 15'h4800, 15'h0009, 15'h0, 15'h7008, 15'h0005, 15'h0, 15'h445a, 15'h6009});
		rd(4'hc);
		chk("acc", d, 32'h5a);
		rd(4'h8);
		chk("pc", d, 32'h9);
		$display("call test done");
		portIn <= 8'h3c;
		boot('{15'h40a5, 15'h0105, 15'h1005, 15'h0003, 15'h0001, 15'h0002, 15'h6006});
		chk("port", 32'(portOut), 32'ha5);
		chk("irq", 32'(irqEnable), 32'h1);
		chk("sleep", 32'(sleeping), 32'h1);
		rd(4'hc);
		chk("acc", d, 32'h3c);
		rd(4'h4);
		chk("tp", 32'(d[12:11]), 32'h2);
		wakeUp <= 1'b1;
		repeat (4) @(posedge clk);
		wakeUp <= 1'b0;
		repeat (10) @(posedge clk);
		chk("sleep", 32'(sleeping), 32'h0);
		rd(4'h8);
		chk("pc", d, 32'h6);
		wdtTimeout <= 1'b1;
		@(posedge clk);
		wdtTimeout <= 1'b0;
		rd(4'h4);
		chk("tp", 32'(d[12:11]), 32'h1);
		$display("sleep test done");
		boot('{15'h6000});
		rd(4'h4);
		chk("status", 32'(d[15:8]), 32'h18);
		chk("port", 32'(portOut), 32'h0);
		chk("irq", 32'(irqEnable), 32'h0);
		$display("reset test done");
		rd(4'h2);
		chk("resp", 32'(r), 32'h2);
		wr(4'h0, 32'h2);
		chk("bresp", 32'(r), 32'h0);
		rd(4'h0);
		chk("ctrl", d, 32'h2);
		$display("bus test done");
		testDone();
	end
endmodule
